// >>> avd_pkg.sv
package avd_pkg;
    // code width and limits
    localparam int          CODE_W     = 10;
    localparam logic [9:0]  CODE_MAX   = 10'h3ff;
    localparam logic [9:0]  CODE_MIN   = 10'h000;
    // register indexes on the plain register port
    localparam int          ADDR_W     = 2;
    localparam logic [1:0]  REG_DAC    = 2'h0;
    localparam logic [1:0]  REG_STEPUP = 2'h1;
    localparam logic [1:0]  REG_STEPDN = 2'h2;
    localparam logic [1:0]  REG_STAT   = 2'h3;
    // reset values
    localparam logic [9:0]  DAC_RST    = 10'h000;
    localparam logic [9:0]  STEP_RST   = 10'h000;
    // status register field positions
    localparam int          STAT_MODE  = 0;
    localparam int          STAT_REF   = 1;

    // register read/write request
    typedef struct packed {
        logic              we;
        logic              re;
        logic [1:0]        addr;
        logic [9:0]        wdata;
    } avd_req_s;

    // step strobe pin pair, both active low
    typedef struct packed {
        logic              up_n;
        logic              dn_n;
    } avd_strobe_s;

    typedef enum logic {AVD_SERIAL, AVD_STEP} avd_mode_e;
endpackage

// >>> avd_step_ctrl.sv
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
// How it works
// R1: mode low: code comes from code register
// R2: mode high: strobes step the code
// R3: step-up and step-down registers give amounts
// R4: both strobes low clears code to zero
// R5: increment pulse with decrement high adds step-up
// R6: controller holds decrement high while pulsing increment
// R7: decrement pulse with increment high subtracts step-down
// R8: controller holds increment high while pulsing decrement
// R9: stepping saturates, never wraps
// R10: reference select low picks internal reference
// R11: reference select high picks external reference
// R12: code register is 10-bit read/write
// R13: step registers are 10-bit read/write
// R14: write with address selects the target register
// R15: step applied on strobe rising edge
// R16: clamp to 1023 up, 0 down
module avd_step_ctrl (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst,
    // register port
    input  wire avd_pkg::avd_req_s         req,
    output logic [avd_pkg::CODE_W-1:0]     rdata,
    // device pins
    input  wire logic                      mode,
    input  wire avd_pkg::avd_strobe_s      strobe,
    input  wire logic                      ref_sel,
    // analog side controls
    output logic [avd_pkg::CODE_W-1:0]     dac_code,
    output logic                           ref_ext_en,
    output logic                           ref_int_en
);
    import avd_pkg::*;

    // positions in the step storage and in the strobe pin vector
    localparam int STEP_UP = 0;
    localparam int STEP_DN = 1;
    localparam int N_STEP  = 2;
    localparam int PIN_DN  = 0;
    localparam int PIN_UP  = 1;
    localparam int N_PIN   = 2;

    // code register and its next value
    logic [CODE_W-1:0] code_reg;
    logic [CODE_W-1:0] code_next;
    // step amounts: flip-flops addressed by index
    logic [CODE_W-1:0] step_reg  [N_STEP];
    logic [CODE_W-1:0] step_next [N_STEP];
    // read data register and its next value
    logic [CODE_W-1:0] rdata_reg;
    logic [CODE_W-1:0] rdata_next;
    // output copy of the code
    logic [CODE_W-1:0] dac_reg;
    // strobe pins as a vector and their rising edges
    logic [N_PIN-1:0]  pin_n;
    wire  [N_PIN-1:0]  pin_rise;
    // reference select copies, one flop per output
    logic              ref_ext_reg;
    logic              ref_int_reg;
    avd_mode_e         mode_e;

    // register index match; every write decode goes through it
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
        reg_hit = (a == idx);
    endfunction

    // saturating add; the extra bit catches overflow instead of wrapping
    function automatic logic [CODE_W-1:0] sat_add(input logic [CODE_W-1:0] a, input logic [CODE_W-1:0] b);
        logic [CODE_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[CODE_W] ? CODE_MAX : s[CODE_W-1:0]; // R9 R16
    endfunction

    // saturating subtract; compare first so the borrow never wraps
    function automatic logic [CODE_W-1:0] sat_sub(input logic [CODE_W-1:0] a, input logic [CODE_W-1:0] b);
        sat_sub = (b > a) ? CODE_MIN : a - b; // R9 R16
    endfunction

    // strobe pins gathered so that the edge logic repeats per pin
    assign pin_n = strobe;

    // one history flop per pin; it resets high, so a pin already low
    // when reset ends gives no step until it has risen
    for (genvar i = 0; i < N_PIN; i++) begin : g_pin
        logic hist_n_reg;
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                hist_n_reg <= 1'b1;
            end else begin
                hist_n_reg <= pin_n[i];
            end
        end
        // a rise ends one completed low pulse
        assign pin_rise[i] = pin_n[i] & ~hist_n_reg; // R15
    end

    // step decode; a rise while the other pin is low is no step
    wire up_step   = pin_rise[PIN_UP] & pin_n[PIN_DN]; // R5 R15
    wire dn_step   = pin_rise[PIN_DN] & pin_n[PIN_UP]; // R7 R15
    wire both_low  = ~pin_n[PIN_UP] & ~pin_n[PIN_DN];  // R4
    assign mode_e  = mode ? AVD_STEP : AVD_SERIAL;
    wire step_mode = (mode_e == AVD_STEP);              // R1 R2

    // write decode
    wire wr_code   = req.we && reg_hit(req.addr, REG_DAC);    // R14
    wire wr_stepup = req.we && reg_hit(req.addr, REG_STEPUP); // R14
    wire wr_stepdn = req.we && reg_hit(req.addr, REG_STEPDN); // R14

    // candidate codes for one step in either direction
    wire [CODE_W-1:0] up_code = sat_add(code_reg, step_reg[STEP_UP]); // R3 R5
    wire [CODE_W-1:0] dn_code = sat_sub(code_reg, step_reg[STEP_DN]); // R3 R7

    // code update; in step mode a pin event wins over a software write,
    // since the host pulsing the pins expects every pulse to count
    always_comb begin
        code_next = code_reg;
        if (step_mode) begin // R2
            if (both_low) begin
                code_next = CODE_MIN; // R4
            end else if (up_step) begin
                code_next = up_code; // R5
            end else if (dn_step) begin
                code_next = dn_code; // R7
            end else if (wr_code) begin
                code_next = req.wdata; // R12
            end
        end else if (wr_code) begin
            code_next = req.wdata; // R1 R12
        end
    end

    // step amount update; software owns these in both modes
    always_comb begin
        step_next[STEP_UP] = step_reg[STEP_UP];
        step_next[STEP_DN] = step_reg[STEP_DN];
        if (wr_stepup) begin
            step_next[STEP_UP] = req.wdata; // R13
        end
        if (wr_stepdn) begin
            step_next[STEP_DN] = req.wdata; // R13
        end
    end

    // readback mux; index 3 is a status word with the mode and reference select pin levels
    always_comb begin
        rdata_next = '0;
        unique case (req.addr)
            REG_DAC: begin
                rdata_next = code_reg; // R12
            end
            REG_STEPUP: begin
                rdata_next = step_reg[STEP_UP]; // R13
            end
            REG_STEPDN: begin
                rdata_next = step_reg[STEP_DN]; // R13
            end
            REG_STAT: begin
                rdata_next[STAT_MODE] = mode;
                rdata_next[STAT_REF]  = ref_sel;
            end
        endcase
        // data stand for one cycle only; zero otherwise keeps the port quiet
        if (!req.re) begin
            rdata_next = '0;
        end
    end

    // code register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            code_reg <= DAC_RST;
        end else begin
            code_reg <= code_next;
        end
    end

    // step amount registers, reset to no step
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int k = 0; k < N_STEP; k++) begin
                step_reg[k] <= STEP_RST;
            end
        end else begin
            for (int k = 0; k < N_STEP; k++) begin
                step_reg[k] <= step_next[k];
            end
        end
    end

    // read data register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // dac output copy; loaded from the next value so it matches the code register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dac_reg <= DAC_RST;
        end else begin
            dac_reg <= code_next;
        end
    end

    // reference select copies; each output has its own flop so neither
    // output carries a gate after the register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ref_ext_reg <= 1'b0;
            ref_int_reg <= 1'b1;
        end else begin
            ref_ext_reg <= ref_sel;  // R11
            ref_int_reg <= ~ref_sel; // R10
        end
    end

    // outputs straight from flops
    assign rdata      = rdata_reg;
    assign dac_code   = dac_reg;
    assign ref_ext_en = ref_ext_reg; // R11
    assign ref_int_en = ref_int_reg; // R10
endmodule // avd_step_ctrl

// >>> avd_properties.sv
`timescale 1ns/1ps
module avd_properties (
    // watched ports
    input logic mclk,
    input logic rst,
    input avd_pkg::avd_req_s req,
    input logic [9:0] rdata,
    input logic mode,
    input avd_pkg::avd_strobe_s strobe,
    input logic ref_sel,
    input logic [9:0] dac_code,
    input logic ref_ext_en,
    input logic ref_int_en
);
    import avd_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // a code write may move the code in either mode
    wire wr0 = req.we && req.addr == REG_DAC;
    a_ref_follow: assert property (1 |=> ref_ext_en == $past(ref_sel) && ref_int_en != ref_ext_en) else $error("ref");
    a_serial_load: assert property (!mode && wr0 |=> dac_code == $past(req.wdata)) else $error("load");
    a_serial_hold: assert property (!mode && !wr0 |=> $stable(dac_code)) else $error("hold");
    a_step_clear: assert property (mode && strobe == 2'b00 |=> dac_code == 0) else $error("clear");
    a_up_no_wrap: assert property (mode && $rose(strobe.up_n) && strobe.dn_n |=> dac_code >= $past(dac_code)) else $error("up");
    a_dn_no_wrap: assert property (mode && $rose(strobe.dn_n) && strobe.up_n |=> dac_code <= $past(dac_code)) else $error("dn");
    a_step_idle: assert property (mode && strobe == 2'b11 && $stable(strobe) && !wr0 |=> $stable(dac_code)) else $error("idle");
    a_read_idle: assert property (!req.re |=> rdata == 0) else $error("rdata");
    c_up: cover property (mode && $rose(strobe.up_n));
    c_top: cover property (dac_code == CODE_MAX);
    c_clr: cover property (mode && strobe == 2'b00);
endmodule // avd_properties

// >>> avd_host.sv
`timescale 1ns/1ps
module avd_host (
    // clock and strobe pins
    input logic mclk,
    output avd_pkg::avd_strobe_s strobe
);
    initial strobe = 2'b11;
    // up lifts first, so a clear ends in a harmless decrement at zero
    task automatic pulse(input avd_pkg::avd_strobe_s lo, input int n);
        @(posedge mclk) strobe <= lo;
        repeat (n) @(posedge mclk);
        strobe <= {1'b1, lo.dn_n};
        @(posedge mclk) strobe <= 2'b11;
        @(posedge mclk);
    endtask
endmodule // avd_host

// >>> tb.sv
`timescale 1ns/1ps
module tb;
    import avd_pkg::*;
    logic mclk = 0, rst = 1, mode = 0, ref_sel = 0, ref_ext_en, ref_int_en;
    avd_req_s req = '0;
    avd_strobe_s strobe;
    logic [9:0] rdata, dac_code, rv[4];
    int n_fail = 0, checked = 0, seed = 32834, code, su, sd, d;
    avd_step_ctrl uut (.mclk, .rst, .req, .rdata, .mode, .strobe, .ref_sel, .dac_code, .ref_ext_en, .ref_int_en);
    avd_host host (.mclk, .strobe);
    initial forever #2.5 mclk = ~mclk;
    // watchdog, far past the few hundred cycles needed
    initial #20000 begin
        n_fail++;
        results();
    end
    task automatic chk(input string nm, input logic [9:0] s, input logic [9:0] e);
        checked++;
        n_fail += (s !== e);
        if (s !== e) $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    endtask
    // one register port cycle; results are looked at just after its edge
    task automatic bus(input logic w, input logic [1:0] a, input logic [9:0] v);
        @(posedge mclk) req <= '{w, !w, a, v};
        @(posedge mclk) req <= '0;
        #1;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 0;
        repeat (4) begin
            d = $random(seed);
            ref_sel <= d[11];
            bus(1, REG_DAC, d[9:0]);
            chk("dac", dac_code, d[9:0]);
            chk("ref", {8'h0, ref_int_en, ref_ext_en}, {8'h0, !d[11], d[11]});
        end
        su = $random(seed);
        sd = $random(seed);
        bus(1, REG_STEPUP, su[9:0]);
        bus(1, REG_STEPDN, sd[9:0]);
        bus(1, REG_STAT, 10'h3ff);
        rv = '{d[9:0], su[9:0], sd[9:0], {8'h0, ref_sel, 1'b0}};
        foreach (rv[i]) begin
            bus(0, i[1:0], 10'h000);
            chk("rd", rdata, rv[i]);
        end
        // random steps, enough to reach both limits
        mode <= 1;
        code = d[9:0];
        repeat (40) begin
            d = $random(seed);
            host.pulse({!d[0], d[0]}, 1 + d[2:1]);
            code = d[0] ? code + su[9:0] : code - sd[9:0];
            code = code > 1023 ? 1023 : code < 0 ? 0 : code;
            #1 chk("step", dac_code, code[9:0]);
        end
        host.pulse(2'b00, 2);
        #1 chk("clr", dac_code, 10'h000);
        mode <= 0;
        host.pulse(2'b01, 1);
        #1 chk("serial", dac_code, 10'h000);
        results();
    end
endmodule // tb
bind avd_step_ctrl avd_properties chk (.mclk, .rst, .req, .rdata, .mode, .strobe, .ref_sel, .dac_code, .ref_ext_en, .ref_int_en);
